// ==== src/timer16_output_ctrl.sv ====
// compare output mode control: apb registers, mode decode, pin muxing, interrupts
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
module timer16_output_ctrl
	import timer16_out_pkg::*;
(
	input  wire logic        clock,            // system clock, 250 MHz
	input  wire logic        reset_n,          // async reset, active low
	input  wire logic        psel,             // apb select
	input  wire logic        penable,          // apb enable
	input  wire logic        pwrite,           // apb write
	input  wire logic [11:0] paddr,            // apb byte address
	input  wire logic [31:0] pwdata,           // apb write data
	output logic      [31:0] prdata,           // apb read data
	output logic             pready,           // apb ready
	output logic             pslverr,          // apb error
	input  wire logic        timer_tick_enable,// prescaled count enable
	input  wire logic [15:0] timer16_count,    // counter value
	input  wire logic        count_down,       // counter decrementing
	input  wire logic        count_bottom_hit, // counter at bottom
	input  wire logic        count_top_hit,    // counter at top
	input  wire logic [15:0] top_value,        // active top value
	input  wire logic        port_a_data,      // ordinary port data, pin a
	input  wire logic        port_b_data,      // ordinary port data, pin b
	output logic             chan_a_wave_out,  // pin a driver level
	output logic             chan_a_wave_oe,   // pin a driver enable
	output logic             chan_b_wave_out,  // pin b driver level
	output logic             chan_b_wave_oe,   // pin b driver enable
	output logic             irq               // level interrupt
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0]  timer16_output_mode_ctrl_reg;
	logic [7:0]  ctrl_b_reg;
	logic [15:0] chan_a_match_value_reg;
	logic [15:0] chan_b_match_value_reg;
	logic [1:0]  pin_dir_reg;
	logic [irq_bits-1:0] status_reg;
	logic [irq_bits-1:0] status_next;
	logic [irq_bits-1:0] irq_en_reg;
	logic [31:0] prdata_next;

	logic [1:0]  chan_a_out_mode;
	logic [1:0]  chan_b_out_mode;
	logic [3:0]  wave_gen_mode;
	logic        wave_gen_mode_b1;
	logic        wave_gen_mode_b0;
	logic [15:0] chan_a_active;
	logic [15:0] chan_b_active;
	logic        match_a;
	logic        match_b;
	logic        wave_a;
	logic        wave_b;
	logic        conn_a;
	logic        conn_b;
	logic [irq_bits-1:0] events;
	logic [irq_bits-1:0] clr_bits;

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	logic wr_en;
	logic rd_en;
	logic hit_ctrl_a;
	logic hit_ctrl_b;
	logic hit_match_a;
	logic hit_match_b;
	logic hit_top;
	logic hit_status;
	logic hit_clr;
	logic hit_en;
	logic hit_dir;
	logic hit_state;
	logic mapped;

	assign pready      = 1'b1;
	assign wr_en       = psel && penable && pwrite;
	assign rd_en       = psel && !penable && !pwrite;
	assign hit_ctrl_a  = (paddr == ctrl_a_offset);
	assign hit_ctrl_b  = (paddr == ctrl_b_offset);
	assign hit_match_a = (paddr == match_a_offset);
	assign hit_match_b = (paddr == match_b_offset);
	assign hit_top     = (paddr == top_offset);
	assign hit_status  = (paddr == status_offset);
	assign hit_clr     = (paddr == irq_clr_offset);
	assign hit_en      = (paddr == irq_en_offset);
	assign hit_dir     = (paddr == pin_dir_offset);
	assign hit_state   = (paddr == state_offset);
	assign mapped      = hit_ctrl_a || hit_ctrl_b || hit_match_a || hit_match_b || hit_top
	                     || hit_status || hit_clr || hit_en || hit_dir || hit_state;
	assign pslverr     = psel && penable && !mapped;

	// read mux; registered during setup so data is stable in the access phase
	assign prdata_next = hit_ctrl_a  ? {24'h000000, timer16_output_mode_ctrl_reg} :
	                     hit_ctrl_b  ? {24'h000000, ctrl_b_reg} :
	                     hit_match_a ? {16'h0000, chan_a_match_value_reg} :
	                     hit_match_b ? {16'h0000, chan_b_match_value_reg} :
	                     hit_top     ? {16'h0000, top_value} :
	                     hit_status  ? {28'h0000000, status_reg} :
	                     hit_en      ? {28'h0000000, irq_en_reg} :
	                     hit_dir     ? {30'h00000000, pin_dir_reg} :
	                     hit_state   ? {28'h0000000, conn_b, conn_a, wave_b, wave_a} :
	                     32'h00000000;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			prdata <= 32'h00000000;
		end else if (rd_en) begin
			prdata <= prdata_next;
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			timer16_output_mode_ctrl_reg <= ctrl_reset;
			ctrl_b_reg                   <= ctrl_reset;
			chan_a_match_value_reg       <= match_reset;
			chan_b_match_value_reg       <= match_reset;
			pin_dir_reg                  <= 2'h0;
			irq_en_reg                   <= '0;
		end else if (wr_en) begin
			if (hit_ctrl_a)
				timer16_output_mode_ctrl_reg <= pwdata[7:0] & ctrl_a_wmask;
			if (hit_ctrl_b)
				ctrl_b_reg <= pwdata[7:0] & ctrl_b_wmask;
			if (hit_match_a)
				chan_a_match_value_reg <= pwdata[15:0];
			if (hit_match_b)
				chan_b_match_value_reg <= pwdata[15:0];
			if (hit_dir)
				pin_dir_reg <= pwdata[1:0];
			if (hit_en)
				irq_en_reg <= pwdata[irq_bits-1:0];
		end
	end

	// ----------------------------------------
	// field extraction
	// ----------------------------------------
	assign chan_a_out_mode  = timer16_output_mode_ctrl_reg[chan_a_mode_lsb +: 2];
	assign chan_b_out_mode  = timer16_output_mode_ctrl_reg[chan_b_mode_lsb +: 2];
	assign wave_gen_mode_b1 = timer16_output_mode_ctrl_reg[wgm_low_lsb + 1];
	assign wave_gen_mode_b0 = timer16_output_mode_ctrl_reg[wgm_low_lsb];
	assign wave_gen_mode    = {ctrl_b_reg[wgm_high_lsb +: 2], wave_gen_mode_b1,
	                           wave_gen_mode_b0};

	// ----------------------------------------
	// channels
	// ----------------------------------------
	chan_wave_unit u_chan_a (
		.clock         (clock),
		.reset_n       (reset_n),
		.tick          (timer_tick_enable),
		.count         (timer16_count),
		.count_down    (count_down),
		.at_bottom     (count_bottom_hit),
		.at_top        (count_top_hit),
		.top_value     (top_value),
		.wave_gen_mode (wave_gen_mode),
		.out_mode      (chan_a_out_mode),
		.is_chan_a     (1'b1),
		.buf_value     (chan_a_match_value_reg),
		.active_value  (chan_a_active),
		.match         (match_a),
		.wave          (wave_a),
		.connected     (conn_a)
	);

	chan_wave_unit u_chan_b (
		.clock         (clock),
		.reset_n       (reset_n),
		.tick          (timer_tick_enable),
		.count         (timer16_count),
		.count_down    (count_down),
		.at_bottom     (count_bottom_hit),
		.at_top        (count_top_hit),
		.top_value     (top_value),
		.wave_gen_mode (wave_gen_mode),
		.out_mode      (chan_b_out_mode),
		.is_chan_a     (1'b0),
		.buf_value     (chan_b_match_value_reg),
		.active_value  (chan_b_active),
		.match         (match_b),
		.wave          (wave_b),
		.connected     (conn_b)
	);

	// ----------------------------------------
	// pin muxing
	// ----------------------------------------
	assign chan_a_wave_out = conn_a ? wave_a : port_a_data;
	assign chan_b_wave_out = conn_b ? wave_b : port_b_data;
	assign chan_a_wave_oe  = pin_dir_reg[0];
	assign chan_b_wave_oe  = pin_dir_reg[1];

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	assign events[irq_match_a] = match_a;
	assign events[irq_match_b] = match_b;
	assign events[irq_bottom]  = timer_tick_enable && count_bottom_hit;
	assign events[irq_top]     = timer_tick_enable && count_top_hit;
	assign clr_bits            = (wr_en && hit_clr) ? pwdata[irq_bits-1:0] : '0;
	// set wins over a clear in the same cycle
	assign status_next         = (status_reg & ~clr_bits) | events;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			status_reg <= '0;
			irq        <= 1'b0;
		end else begin
			status_reg <= status_next;
			irq        <= |(status_next & irq_en_reg);
		end
	end
endmodule

// ==== src/timer16_out_pkg.sv ====
// package: register map, field layout and mode codes of the compare output block
package timer16_out_pkg;
	localparam logic [11:0] ctrl_a_offset   = 12'h080;
	localparam logic [11:0] ctrl_b_offset   = 12'h084;
	localparam logic [11:0] match_a_offset  = 12'h088;
	localparam logic [11:0] match_b_offset  = 12'h08C;
	localparam logic [11:0] top_offset      = 12'h090;
	localparam logic [11:0] status_offset   = 12'h094;
	localparam logic [11:0] irq_clr_offset  = 12'h098;
	localparam logic [11:0] irq_en_offset   = 12'h09C;
	localparam logic [11:0] pin_dir_offset  = 12'h0A0;
	localparam logic [11:0] state_offset    = 12'h0A4;
	localparam int          chan_a_mode_lsb = 6;
	localparam int          chan_b_mode_lsb = 4;
	localparam int          wgm_low_lsb     = 0;
	localparam int          wgm_high_lsb    = 3;
	localparam logic [7:0]  ctrl_a_wmask    = 8'hF3;
	localparam logic [7:0]  ctrl_b_wmask    = 8'h18;
	localparam logic [7:0]  ctrl_reset      = 8'h00;
	localparam logic [15:0] match_reset     = 16'h0000;
	localparam logic [15:0] top_reset       = 16'hFFFF;
	localparam logic [15:0] count_bottom    = 16'h0000;
	localparam int          irq_bits        = 4;
	localparam int          irq_match_a     = 0;
	localparam int          irq_match_b     = 1;
	localparam int          irq_bottom      = 2;
	localparam int          irq_top         = 3;
	localparam logic [1:0]  com_off         = 2'h0;
	localparam logic [1:0]  com_toggle      = 2'h1;
	localparam logic [1:0]  com_clear       = 2'h2;
	localparam logic [1:0]  com_set         = 2'h3;
	localparam logic [3:0]  wgm_fast_icr    = 4'hE;
	localparam logic [3:0]  wgm_fast_ocr    = 4'hF;
	localparam logic [3:0]  wgm_pfc_ocr     = 4'h9;
	localparam logic [3:0]  wgm_pc_ocr      = 4'hB;
	typedef enum logic [2:0] {
		class_nonpwm = 3'h1,
		class_fast   = 3'h2,
		class_dual   = 3'h4
	} wave_class_t;
endpackage

// ==== src/chan_wave_unit.sv ====
// one compare channel: match value buffer and output waveform flip-flop
`timescale 1ns/100ps
module chan_wave_unit
	import timer16_out_pkg::*;
(
	input  wire logic        clock,          // system clock
	input  wire logic        reset_n,        // async reset, active low
	input  wire logic        tick,           // timer tick enable
	input  wire logic [15:0] count,          // counter value
	input  wire logic        count_down,     // counter decrementing
	input  wire logic        at_bottom,      // bottom strobe
	input  wire logic        at_top,         // top strobe
	input  wire logic [15:0] top_value,      // active top value
	input  wire logic [3:0]  wave_gen_mode,  // waveform mode
	input  wire logic [1:0]  out_mode,       // channel output mode field
	input  wire logic        is_chan_a,      // channel a toggle privilege
	input  wire logic [15:0] buf_value,      // software match buffer
	output logic      [15:0] active_value,   // active match value
	output logic             match,          // match pulse
	output logic             wave,           // waveform level
	output logic             connected       // output owns pin
);
	wave_class_t wclass;
	logic        buffered;
	logic        load_at_bottom;
	logic        load_now;
	logic        hit;
	logic        toggle_ok;
	logic        top_ignore;
	logic        do_set;
	logic        do_clr;
	logic        do_tog;
	logic        wave_next;
	logic [15:0] active_next;

	// mode classes
	assign wclass = (wave_gen_mode == 4'h0 || wave_gen_mode == 4'h4 || wave_gen_mode == 4'hC
	                 || wave_gen_mode == 4'hD) ? class_nonpwm :
	                (wave_gen_mode == 4'h5 || wave_gen_mode == 4'h6 || wave_gen_mode == 4'h7
	                 || wave_gen_mode == 4'hE || wave_gen_mode == 4'hF) ? class_fast : class_dual;
	assign buffered       = (wclass != class_nonpwm);
	assign load_at_bottom = (wclass == class_fast) || (wave_gen_mode == 4'h8)
	                        || (wave_gen_mode == wgm_pfc_ocr);
	assign load_now       = !buffered || (tick && (load_at_bottom ? at_bottom : at_top));
	assign active_next    = load_now ? buf_value : active_value;
	assign hit            = tick && (count == active_value);
	assign toggle_ok      = is_chan_a && (((wclass == class_fast) && (wave_gen_mode == wgm_fast_icr
	                        || wave_gen_mode == wgm_fast_ocr)) || ((wclass == class_dual)
	                        && (wave_gen_mode == wgm_pfc_ocr || wave_gen_mode == wgm_pc_ocr)));
	assign connected      = (out_mode != com_off) && ((out_mode != com_toggle)
	                        || (wclass == class_nonpwm) || toggle_ok);
	assign top_ignore     = (wclass == class_fast) && out_mode[1]
	                        && (active_value == top_value);

	always_comb begin
		do_set = 1'b0;
		do_clr = 1'b0;
		do_tog = 1'b0;
		case (wclass)
			class_nonpwm: begin
				do_tog = hit && (out_mode == com_toggle);
				do_clr = hit && (out_mode == com_clear);
				do_set = hit && (out_mode == com_set);
			end
			class_fast: begin
				do_tog = hit && (out_mode == com_toggle) && toggle_ok;
				do_clr = (hit && !top_ignore && out_mode == com_clear)
				         || (tick && at_bottom && out_mode == com_set);
				do_set = (hit && !top_ignore && out_mode == com_set)
				         || (tick && at_bottom && out_mode == com_clear);
			end
			class_dual: begin
				do_tog = hit && (out_mode == com_toggle) && toggle_ok;
				do_clr = hit && ((out_mode == com_clear && !count_down)
				         || (out_mode == com_set && count_down));
				do_set = hit && ((out_mode == com_set && !count_down)
				         || (out_mode == com_clear && count_down));
			end
			default: begin
				do_tog = 1'b0;
			end
		endcase
	end

	// fast pwm: bottom action after a match in the same tick wins
	// only the clear and set modes act at bottom, toggle leaves the level alone
	assign wave_next = do_tog ? !wave
	                   : (wclass == class_fast && tick && at_bottom && out_mode[1])
	                   ? (out_mode == com_clear) : do_set ? 1'b1 : do_clr ? 1'b0 : wave;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wave         <= 1'b0;
			active_value <= match_reset;
			match        <= 1'b0;
		end else begin
			wave         <= wave_next;
			active_value <= active_next;
			match        <= hit;
		end
	end
endmodule

// ==== test/pin_load_model.sv ====
// far-side load on a compare output pin: driver with weak pull
`timescale 1ns/100ps
module pin_load_model #(
	parameter logic pull_level = 1'b0 // level when released
) (
	input  wire logic level,  // driver level
	input  wire logic enable, // driver enable
	output logic      pin     // resolved pin level
);
	assign pin = enable ? level : pull_level;
endmodule

// ==== test/timer16_output_ctrl_assertions.sv ====
// checker: port relations of the compare output control block
`timescale 1ns/100ps
module timer16_output_ctrl_assertions
	import timer16_out_pkg::*;
(
	input wire logic        clock,             // system clock
	input wire logic        reset_n,           // async reset
	input wire logic        psel,              // apb select
	input wire logic        penable,           // apb enable
	input wire logic        pwrite,            // apb write
	input wire logic [11:0] paddr,             // apb address
	input wire logic [31:0] pwdata,            // apb write data
	input wire logic [31:0] prdata,            // apb read data
	input wire logic        timer_tick_enable, // count enable
	input wire logic [15:0] timer16_count,     // counter value
	input wire logic        count_bottom_hit,  // at bottom
	input wire logic        port_a_data,       // port data a
	input wire logic        port_b_data,       // port data b
	input wire logic        chan_a_wave_out,   // pin a level
	input wire logic        chan_a_wave_oe,    // pin a enable
	input wire logic        chan_b_wave_out    // pin b level
);
	logic [7:0]  ca_reg, cb_reg;
	logic [15:0] ma_reg;
	wire         wr = psel && penable && pwrite;
	wire  [3:0]  wm = {cb_reg[4:3], ca_reg[1:0]};
	wire  [1:0]  ma = ca_reg[7:6];
	wire         nonpwm = wm inside {4'h0, 4'h4, 4'hC, 4'hD};
	wire         fast = wm inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF};
	wire         hit = timer_tick_enable && timer16_count == ma_reg && !wr;
	// ------------------------------------------------
	// shadow of control and match buffer
	// ------------------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ca_reg <= 8'h00;
			cb_reg <= 8'h00;
			ma_reg <= 16'h0000;
		end else if (wr) begin
			if (paddr == ctrl_a_offset) ca_reg <= pwdata[7:0];
			if (paddr == ctrl_b_offset) cb_reg <= pwdata[7:0];
			if (paddr == match_a_offset) ma_reg <= pwdata[15:0];
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	disc_pass_a: assert property (ma == com_off |-> chan_a_wave_out == port_a_data)
		else $error("pin a left port data");
	set_match_a: assert property (nonpwm && ma == com_set && hit |=> chan_a_wave_out)
		else $error("set on match missed");
	clear_match_a: assert property (nonpwm && ma == com_clear && hit |=> !chan_a_wave_out)
		else $error("clear on match missed");
	toggle_match_a: assert property (nonpwm && ma == com_toggle && hit
		|=> chan_a_wave_out != $past(chan_a_wave_out)) else $error("toggle missed");
	fast_b_off_a: assert property (fast && ca_reg[5:4] == com_toggle
		|-> chan_b_wave_out == port_b_data) else $error("pin b toggled in fast mode");
	bottom_set_a: assert property (fast && ma == com_clear && timer_tick_enable
		&& count_bottom_hit && !wr |=> chan_a_wave_out) else $error("bottom set missed");
	idle_hold_a: assert property ((!timer_tick_enable && !psel) ##1 $stable(port_a_data)
		|-> $stable(chan_a_wave_out)) else $error("pin a moved without tick");
	dir_hold_a: assert property (!(wr && paddr == pin_dir_offset)
		|=> $stable(chan_a_wave_oe)) else $error("pin a enable moved");
	rsvd_zero_a: assert property (psel && penable && !pwrite && paddr == ctrl_a_offset
		|-> prdata[3:2] == 2'h0 && prdata[31:8] == 24'h0) else $error("reserved bits set");
	cover property (nonpwm && hit);
	cover property (fast && timer_tick_enable && count_bottom_hit);
	cover property (!nonpwm && !fast && timer_tick_enable);
endmodule
bind timer16_output_ctrl timer16_output_ctrl_assertions chk_u (.clock, .reset_n, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .timer_tick_enable, .timer16_count,
	.count_bottom_hit, .port_a_data, .port_b_data, .chan_a_wave_out, .chan_a_wave_oe,
	.chan_b_wave_out);

// ==== test/timer16_compare_output_ctrl_tb.sv ====
// self-checking bench for the compare output control block
`timescale 1ns/100ps
module timer16_compare_output_ctrl_tb;
	import timer16_out_pkg::*;
	logic        clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [15:0] cnt = '0, top_value = 16'hFFFF;
	logic        pready, pslverr, err, tick = 0, down = 0, bot = 0, top = 0;
	logic        pa = 0, pb = 0, oa, ea, ob, eb, irq, pin_a, pin_b, was;
	int          errors = 0, checks = 0, cycles = 0;
	timer16_output_ctrl dut_u (.clock, .reset_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .timer_tick_enable(tick), .timer16_count(cnt),
		.count_down(down), .count_bottom_hit(bot), .count_top_hit(top), .top_value,
		.port_a_data(pa), .port_b_data(pb), .chan_a_wave_out(oa), .chan_a_wave_oe(ea),
		.chan_b_wave_out(ob), .chan_b_wave_oe(eb), .irq);
	pin_load_model pa_u (.level(oa), .enable(ea), .pin(pin_a));
	pin_load_model pb_u (.level(ob), .enable(eb), .pin(pin_b));
	always #2 clock = ~clock;
	// ------------------------------------------------
	// shared tasks
	// ------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t %s: saw %h want %h", $time, what, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		@(negedge clock);
	endtask
	task automatic mode(input logic [3:0] w, input logic [1:0] ca, input logic [1:0] cb);
		wr(ctrl_a_offset, {24'h0, ca, cb, 2'h0, w[1:0]});
		wr(ctrl_b_offset, {27'h0, w[3:2], 3'h0});
	endtask
	task automatic step(input logic [15:0] c, input logic dn, input logic bt, input logic tp);
		@(posedge clock);
		tick <= 1'b1;
		cnt <= c;
		down <= dn;
		bot <= bt;
		top <= tp;
		@(posedge clock);
		tick <= 1'b0;
		bot <= 1'b0;
		top <= 1'b0;
		@(negedge clock);
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// ------------------------------------------------
	// scenarios
	// ------------------------------------------------
	task automatic t_regs;
		apb(1'b0, ctrl_a_offset, 32'h0);
		chk(rd, 32'h0, "ctrl reset");
		wr(ctrl_a_offset, 32'hFF);
		apb(1'b0, ctrl_a_offset, 32'h0);
		chk(rd, 32'hF3, "ctrl reserved");
		apb(1'b0, 12'h0FC, 32'h0);
		chk(err, 1'b1, "unmapped");
		chk(pready, 1'b1, "ready");
		mode(4'h0, com_off, com_off);
		$display("test regs done");
	endtask
	task automatic t_nonpwm;
		logic [1:0] coms [4] = '{com_set, com_clear, com_toggle, com_toggle};
		logic [3:0] wgms [4] = '{4'h0, 4'h4, 4'hC, 4'hD};
		logic       exps [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
		@(posedge clock) pa <= 1'b1;
		wr(pin_dir_offset, 32'h3);
		chk(pin_a, 1'b1, "port pass");
		wr(pin_dir_offset, 32'h2);
		chk(pin_a, 1'b0, "released");
		wr(pin_dir_offset, 32'h3);
		for (int i = 0; i < 4; i++) begin
			mode(wgms[i], coms[i], coms[i]);
			wr(match_a_offset, 32'h10);
			wr(match_b_offset, 32'h10);
			step(16'h10, 1'b0, 1'b0, 1'b0);
			chk(pin_a, exps[i], "nonpwm match");
			chk(pin_b, exps[i], "nonpwm match b");
		end
		step(16'h11, 1'b0, 1'b0, 1'b0);
		chk(pin_a, 1'b0, "no match");
		$display("test nonpwm done");
	endtask
	task automatic t_fast;
		@(posedge clock) pb <= 1'b1;
		mode(4'hE, com_toggle, com_toggle);
		wr(match_a_offset, 32'h20);
		step(16'h0, 1'b0, 1'b1, 1'b0);
		was = pin_a;
		step(16'h20, 1'b0, 1'b0, 1'b0);
		chk(pin_a, !was, "fast toggle");
		chk(pin_b, 1'b1, "fast b off");
		step(16'h0, 1'b0, 1'b1, 1'b0);
		chk(pin_a, !was, "toggle at bottom");
		mode(4'h5, com_toggle, com_off);
		chk(pin_a, 1'b1, "mode5 off");
		mode(4'hE, com_clear, com_off);
		step(16'h20, 1'b0, 1'b0, 1'b0);
		chk(pin_a, 1'b0, "match clear");
		step(16'h0, 1'b0, 1'b1, 1'b0);
		chk(pin_a, 1'b1, "bottom set");
		mode(4'hE, com_set, com_off);
		step(16'h0, 1'b0, 1'b1, 1'b0);
		chk(pin_a, 1'b0, "bottom clear");
		step(16'h20, 1'b0, 1'b0, 1'b0);
		chk(pin_a, 1'b1, "match set");
		@(posedge clock) top_value <= 16'h0020;
		mode(4'hE, com_clear, com_off);
		step(16'h0, 1'b0, 1'b1, 1'b0);
		step(16'h20, 1'b0, 1'b0, 1'b1);
		chk(pin_a, 1'b1, "top match ignored");
		@(posedge clock) top_value <= 16'hFFFF;
		$display("test fast done");
	endtask
	task automatic t_dual;
		mode(4'hA, com_clear, com_off);
		wr(match_a_offset, 32'h30);
		step(16'hFF, 1'b0, 1'b0, 1'b1);
		step(16'h30, 1'b0, 1'b0, 1'b0);
		chk(pin_a, 1'b0, "up clear");
		step(16'h30, 1'b1, 1'b0, 1'b0);
		chk(pin_a, 1'b1, "down set");
		mode(4'hA, com_set, com_off);
		step(16'h30, 1'b1, 1'b0, 1'b0);
		chk(pin_a, 1'b0, "down clear");
		step(16'h30, 1'b0, 1'b0, 1'b0);
		chk(pin_a, 1'b1, "up set");
		mode(4'hA, com_toggle, com_toggle);
		chk({pin_b, pin_a}, 2'h3, "mode10 off");
		mode(4'h9, com_toggle, com_toggle);
		was = pin_a;
		step(16'h30, 1'b0, 1'b0, 1'b0);
		chk({pin_b, pin_a}, {1'b1, !was}, "mode9 toggle");
		mode(4'h8, com_clear, com_off);
		wr(match_a_offset, 32'h40);
		step(16'h30, 1'b1, 1'b0, 1'b0);
		step(16'hFF, 1'b0, 1'b0, 1'b1);
		step(16'h40, 1'b0, 1'b0, 1'b0);
		chk(pin_a, 1'b1, "no top load");
		step(16'h0, 1'b1, 1'b1, 1'b0);
		step(16'h40, 1'b0, 1'b0, 1'b0);
		chk(pin_a, 1'b0, "bottom load");
		$display("test dual done");
	endtask
	task automatic t_irq;
		mode(4'h0, com_set, com_off);
		wr(match_a_offset, 32'h50);
		wr(irq_clr_offset, 32'hF);
		wr(irq_en_offset, 32'h1);
		step(16'h50, 1'b0, 1'b0, 1'b0);
		@(negedge clock);
		chk(irq, 1'b1, "irq raised");
		apb(1'b0, status_offset, 32'h0);
		chk(rd, 32'h1, "status");
		apb(1'b0, state_offset, 32'h0);
		chk(rd, 32'h5, "state");
		wr(irq_clr_offset, 32'h1);
		@(negedge clock);
		chk(irq, 1'b0, "irq cleared");
		wr(irq_en_offset, 32'h0);
		step(16'h50, 1'b0, 1'b0, 1'b0);
		@(negedge clock);
		chk(irq, 1'b0, "irq masked");
		wr(irq_en_offset, 32'h1);
		@(negedge clock);
		chk(irq, 1'b1, "irq unmasked");
		$display("test irq done");
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			complete_run();
		end
	end
	initial begin
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		t_regs();
		t_nonpwm();
		t_fast();
		t_dual();
		t_irq();
		complete_run();
	end
endmodule
